// *** vram_cfg_pkg.sv ***
// Shared constants and types for the VRAM bank-select and refresh block.
// Assumes a single 10 MHz system clock and a classic Wishbone register port.
`default_nettype none

package vram_cfg_pkg;

    // Register byte offsets
    localparam logic [3:0] CFG_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;

    // Field positions in the configuration word
    localparam int CLK_DIV_LSB = 0;
    localparam int FINE_DIV_POS = 3;
    localparam int STROBE_CFG_LSB = 4;
    localparam int PIPE_POS = 8;
    localparam int STAGGER_POS = 9;

    // Reset value of the configuration word
    localparam logic [9:0] CFG_RESET = 10'h000;

    // Divider and refresh timing
    localparam logic [3:0] DIV_BASE = 4'ha;
    localparam logic [4:0] FINE_DIV_LO = 5'h1e;
    localparam logic [4:0] FINE_DIV_HI = 5'h1a;
    localparam logic [1:0] REFRESH_LOW_CYCLES = 2'h2;
    localparam logic [1:0] COL_HOLD_CYCLES = 2'h1;

    typedef struct packed {
        logic refresh_stagger_sel;
        logic addr_pipeline_sel;
        logic [2:0] strobe_config_field;
        logic refresh_fine_divisor;
        logic [2:0] clock_divisor_field;
    } cfg_t;

    typedef struct packed {
        logic [3:0] row;
        logic [3:0] col;
        logic scrub;
        logic pair_stagger;
    } strobe_sel_t;

endpackage : vram_cfg_pkg

`default_nettype wire

// *** strobe_decode.sv ***
// Maps the strobe configuration field and bank-select bits onto strobe sets.
// Purely combinational; the caller registers what it uses.
`default_nettype none

module strobe_decode (
    input wire logic [2:0] strobe_config_field_i, // Strobe mode
    input wire logic bank_sel_lo_i,               // Bank-select bit zero
    input wire logic bank_sel_hi_i,               // Bank-select bit one
    output vram_cfg_pkg::strobe_sel_t sel_o       // Decoded strobes
);

    function automatic logic [3:0] one_hot(input logic [1:0] idx);
        one_hot = 4'h1 << idx;
    endfunction : one_hot

    function automatic logic [3:0] pair_of(input logic hi);
        pair_of = hi ? 4'hc : 4'h3;
    endfunction : pair_of

    always_comb begin
        sel_o = '0;
        // All-strobe mode 0,1,1 is a row-only refresh with no scrubbing
        sel_o.scrub = ~strobe_config_field_i[2] & (strobe_config_field_i != 3'h3);
        case (strobe_config_field_i)
            3'h1: begin
                sel_o.row = pair_of(bank_sel_hi_i);
                sel_o.col = pair_of(bank_sel_hi_i);
                sel_o.pair_stagger = 1'b1;
            end
            3'h2: begin
                sel_o.row = one_hot({bank_sel_hi_i, bank_sel_lo_i});
                sel_o.col = one_hot({bank_sel_hi_i, bank_sel_lo_i});
            end
            3'h4: begin
                sel_o.row = pair_of(bank_sel_hi_i);
                sel_o.col = 4'hf;
                sel_o.pair_stagger = 1'b1;
            end
            3'h5: begin
                sel_o.row = pair_of(bank_sel_hi_i);
                sel_o.col = pair_of(bank_sel_hi_i);
                sel_o.pair_stagger = 1'b1;
            end
            3'h6: begin
                sel_o.row = one_hot({bank_sel_hi_i, bank_sel_lo_i});
                sel_o.col = 4'hf;
            end
            3'h7: begin
                sel_o.row = one_hot({bank_sel_hi_i, bank_sel_lo_i});
                sel_o.col = one_hot({bank_sel_hi_i, bank_sel_lo_i});
            end
            default: begin
                sel_o.row = 4'hf;
                sel_o.col = 4'hf;
            end
        endcase
    end

endmodule : strobe_decode

`default_nettype wire

// *** refresh_divider.sv ***
// Divides the delay-line clock input down to the internal tick and the
// refresh request pulse. The input is sampled as a synchronous level.
`default_nettype none

module refresh_divider (
    input wire logic clk_i,                       // System clock
    input wire logic rst_i,                       // Sync reset, high
    input wire logic delay_line_clock_in_i,       // Delay-line clock level
    input wire logic [2:0] clock_divisor_field_i, // Divisor code
    input wire logic refresh_fine_divisor_i,      // Fine divisor select
    output logic div_tick_o,                      // Divided clock pulse
    output logic refresh_tick_o                   // Refresh request pulse
);

    logic dlc_prev_r;
    logic [3:0] div_cnt_r;
    logic [4:0] ref_cnt_r;
    logic dlc_rise;
    logic [3:0] div_last;
    logic [4:0] ref_last;

    assign dlc_rise = delay_line_clock_in_i & ~dlc_prev_r;
    assign div_last = vram_cfg_pkg::DIV_BASE - {1'b0, clock_divisor_field_i} - 4'h1;
    assign ref_last = (refresh_fine_divisor_i ? vram_cfg_pkg::FINE_DIV_HI
                                              : vram_cfg_pkg::FINE_DIV_LO) - 5'h01;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dlc_prev_r <= 1'b0;
        end else begin
            dlc_prev_r <= delay_line_clock_in_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_r <= 4'h0;
            div_tick_o <= 1'b0;
        end else begin
            div_tick_o <= 1'b0;
            if (dlc_rise) begin
                if (div_cnt_r >= div_last) begin
                    div_cnt_r <= 4'h0;
                    div_tick_o <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 4'h1;
                end
            end
        end
    end

    // Same divided tick drives the refresh timer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_cnt_r <= 5'h00;
            refresh_tick_o <= 1'b0;
        end else begin
            refresh_tick_o <= 1'b0;
            if (div_tick_o) begin
                if (ref_cnt_r >= ref_last) begin
                    ref_cnt_r <= 5'h00;
                    refresh_tick_o <= 1'b1;
                end else begin
                    ref_cnt_r <= ref_cnt_r + 5'h01;
                end
            end
        end
    end

endmodule : refresh_divider

`default_nettype wire

// *** vram_bank_select_refresh_cfg.sv ***
// Strobe selection, refresh sequencing and address muxing for a VRAM array.
// Assumes a classic Wishbone master and synchronous pin inputs at 10 MHz.
//
// Summary of operation
// - A column strobe is driven only if its byte column-enable input was high at the previous clock edge.
// - Mode 1,0,0 picks a row pair by bank bit one, all columns are candidates, bit zero ignored, no scrubbing.
// - In that mode bank bit one low gives row strobes 0-1 and high gives 2-3, with columns 0-3.
// - Mode 1,0,1 picks row and column pair 0-1 or 2-3 by bank bit one, bit zero ignored, no scrubbing.
// - Mode 1,1,0 picks the single row strobe numbered by both bank bits, with all columns as candidates.
// - Mode 1,1,1 picks the single row and same-numbered column strobe by both bank bits, no scrubbing.
// - The fine divisor bit divides the divided clock further by 30 when low or 26 when high.
// - The divisor field divides the delay-line clock by 10 down to 3 for codes 000 to 111.
// - The one divided clock feeds both the delay line and the refresh timer.
// - With stagger off, all four row strobes assert and negate together in refresh.
// - With stagger on, refresh row strobes step in one clock apart, one or two per step by mode.
// - Without pipelining the address returns from column to row once column hold is met.
// - With pipelining the column address stays until the access row strobes negate.
`default_nettype none

module vram_bank_select_refresh_cfg (
    input wire logic clk_i,                  // System clock, 10 MHz
    input wire logic rst_i,                  // Sync reset, high
    input wire logic wb_cyc_i,               // Wishbone cycle
    input wire logic wb_stb_i,               // Wishbone strobe
    input wire logic wb_we_i,                // Wishbone write
    input wire logic [3:0] wb_adr_i,         // Byte address
    input wire logic [3:0] wb_sel_i,         // Byte lanes
    input wire logic [31:0] wb_dat_i,        // Write data
    output logic [31:0] wb_dat_o,            // Read data
    output logic wb_ack_o,                   // Acknowledge
    input wire logic access_req_i,           // Memory access request level
    input wire logic bank_sel_lo_i,          // Bank-select bit zero
    input wire logic bank_sel_hi_i,          // Bank-select bit one
    input wire logic [3:0] byte_col_enable_i, // Byte column enables
    input wire logic [10:0] row_addr_i,      // Row address
    input wire logic [10:0] col_addr_i,      // Column address
    input wire logic delay_line_clock_in_i,  // Delay-line clock level
    output logic [3:0] row_strobe_o,         // Row strobes, high active
    output logic [3:0] col_strobe_o,         // Column strobes, high active
    output logic [10:0] mem_addr_o,          // Memory address
    output logic scrub_o,                    // Scrubbing refresh in progress
    output logic delay_tick_o                // Divided clock to delay line
);

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ROW = 5'b00010,
        ST_COL = 5'b00100,
        ST_HOLD = 5'b01000,
        ST_REF = 5'b10000
    } state_t;

    state_t state_r;
    vram_cfg_pkg::cfg_t cfg_r;
    vram_cfg_pkg::cfg_t cfg_stage_r;
    logic cfg_dirty_r;
    vram_cfg_pkg::strobe_sel_t dec;
    logic [3:0] col_sel_r;
    logic [1:0] cnt_r;
    logic [1:0] step_r;
    logic refresh_pend_r;
    logic refresh_tick;
    logic div_tick;
    logic refresh_done;
    logic bus_req;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    strobe_decode u_decode (
        .strobe_config_field_i(cfg_r.strobe_config_field),
        .bank_sel_lo_i(bank_sel_lo_i),
        .bank_sel_hi_i(bank_sel_hi_i),
        .sel_o(dec)
    );

    refresh_divider u_divider (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .delay_line_clock_in_i(delay_line_clock_in_i),
        .clock_divisor_field_i(cfg_r.clock_divisor_field),
        .refresh_fine_divisor_i(cfg_r.refresh_fine_divisor),
        .div_tick_o(div_tick),
        .refresh_tick_o(refresh_tick)
    );

    function automatic logic [3:0] stagger_group(input logic pair, input logic [1:0] s);
        if (pair) begin
            stagger_group = s[0] ? 4'hc : 4'h3;
        end else begin
            stagger_group = 4'h1 << s;
        end
    endfunction : stagger_group

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            delay_tick_o <= 1'b0;
        end else begin
            delay_tick_o <= div_tick;
        end
    end

    // Bus slave: one wait state, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0000_0000;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    vram_cfg_pkg::CFG_OFFSET: wb_dat_o <= {22'h000000, cfg_r[8:7], 1'b0, cfg_r[6:0]};
                    vram_cfg_pkg::STATUS_OFFSET: wb_dat_o <= {12'h000, 3'h0, state_r, 1'b0,
                                                              refresh_pend_r, 1'b0, scrub_o,
                                                              col_strobe_o, row_strobe_o};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Writes are staged and only applied between cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_stage_r <= vram_cfg_pkg::CFG_RESET[8:0];
            cfg_dirty_r <= 1'b0;
            cfg_r <= vram_cfg_pkg::CFG_RESET[8:0];
        end else begin
            if (bus_req && wb_we_i && wb_adr_i == vram_cfg_pkg::CFG_OFFSET) begin
                if (wb_sel_i[0]) begin
                    cfg_stage_r.clock_divisor_field <= wb_dat_i[vram_cfg_pkg::CLK_DIV_LSB +: 3];
                    cfg_stage_r.refresh_fine_divisor <= wb_dat_i[vram_cfg_pkg::FINE_DIV_POS];
                    cfg_stage_r.strobe_config_field <= wb_dat_i[vram_cfg_pkg::STROBE_CFG_LSB +: 3];
                end
                if (wb_sel_i[1]) begin
                    cfg_stage_r.addr_pipeline_sel <= wb_dat_i[vram_cfg_pkg::PIPE_POS];
                    cfg_stage_r.refresh_stagger_sel <= wb_dat_i[vram_cfg_pkg::STAGGER_POS];
                end
                cfg_dirty_r <= 1'b1;
            end else if (cfg_dirty_r && state_r == ST_IDLE) begin
                cfg_r <= cfg_stage_r;
                cfg_dirty_r <= 1'b0;
            end
        end
    end

    // Set wins over clear so a tick at completion is kept
    assign refresh_done = (state_r == ST_REF) && (cnt_r == vram_cfg_pkg::REFRESH_LOW_CYCLES - 2'h1)
                          && (!cfg_r.refresh_stagger_sel || row_strobe_o == 4'hf);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            refresh_pend_r <= 1'b0;
        end else begin
            refresh_pend_r <= refresh_tick | (refresh_pend_r & ~refresh_done);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            row_strobe_o <= 4'h0;
            col_sel_r <= 4'h0;
            mem_addr_o <= 11'h000;
            cnt_r <= 2'h0;
            step_r <= 2'h0;
            scrub_o <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    cnt_r <= 2'h0;
                    mem_addr_o <= row_addr_i;
                    if (refresh_pend_r && !cfg_dirty_r) begin
                        state_r <= ST_REF;
                        scrub_o <= dec.scrub;
                        if (cfg_r.refresh_stagger_sel) begin
                            row_strobe_o <= stagger_group(dec.pair_stagger, 2'h0);
                            step_r <= 2'h1;
                        end else begin
                            row_strobe_o <= 4'hf;
                        end
                    end else if (access_req_i && !cfg_dirty_r) begin
                        state_r <= ST_ROW;
                        row_strobe_o <= dec.row;
                        col_sel_r <= dec.col;
                    end
                end
                ST_ROW: begin
                    state_r <= ST_COL;
                    mem_addr_o <= col_addr_i;
                end
                ST_COL: begin
                    cnt_r <= cnt_r + 2'h1;
                    if (cnt_r == vram_cfg_pkg::COL_HOLD_CYCLES - 2'h1) begin
                        state_r <= ST_HOLD;
                        if (!cfg_r.addr_pipeline_sel) begin
                            mem_addr_o <= row_addr_i;
                        end
                    end
                end
                ST_HOLD: begin
                    if (!access_req_i) begin
                        state_r <= ST_IDLE;
                        row_strobe_o <= 4'h0;
                        col_sel_r <= 4'h0;
                        mem_addr_o <= row_addr_i;
                    end
                end
                ST_REF: begin
                    // Stepping ends once every strobe is up; a 2-bit step could never pass 3
                    if (cfg_r.refresh_stagger_sel && row_strobe_o != 4'hf) begin
                        row_strobe_o <= row_strobe_o | stagger_group(dec.pair_stagger, step_r);
                        step_r <= step_r + 2'h1;
                    end else begin
                        cnt_r <= cnt_r + 2'h1;
                    end
                    if (refresh_done) begin
                        state_r <= ST_IDLE;
                        row_strobe_o <= 4'h0;
                        scrub_o <= 1'b0;
                        step_r <= 2'h0;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Column enables gate every selected strobe, in every mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            col_strobe_o <= 4'h0;
        end else if (state_r == ST_COL || (state_r == ST_HOLD && access_req_i)) begin
            col_strobe_o <= col_sel_r & byte_col_enable_i;
        end else begin
            col_strobe_o <= 4'h0;
        end
    end

    a_col_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        (col_strobe_o & ~$past(byte_col_enable_i)) == 4'h0)
        else $error("column strobe driven without its enable");

    a_pair_mode_row: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_IDLE && access_req_i && !refresh_pend_r && !cfg_dirty_r
         && cfg_r.strobe_config_field == 3'h4) |=> row_strobe_o == (bank_sel_hi_i ? 4'hc : 4'h3))
        else $error("pair mode row strobes wrong");

    a_single_row: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_IDLE && access_req_i && !refresh_pend_r && !cfg_dirty_r
         && cfg_r.strobe_config_field == 3'h6) |=> $onehot(row_strobe_o))
        else $error("single mode row strobe not one-hot");

    a_single_col: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_COL && cfg_r.strobe_config_field == 3'h7) |=> (col_strobe_o & ~row_strobe_o) == 4'h0)
        else $error("single mode column differs from row");

    a_no_scrub: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_r.strobe_config_field[2] |-> !scrub_o)
        else $error("scrubbing in a no-scrub mode");

    a_ref_together: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_IDLE && refresh_pend_r && !cfg_dirty_r && !cfg_r.refresh_stagger_sel)
        |=> row_strobe_o == 4'hf ##1 row_strobe_o == 4'hf ##1 row_strobe_o == 4'h0)
        else $error("simultaneous refresh strobes wrong");

    a_ref_stagger: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_REF && cfg_r.refresh_stagger_sel && row_strobe_o != 4'hf)
        |=> $countones(row_strobe_o) > $countones($past(row_strobe_o)))
        else $error("staggered refresh did not step");

    a_addr_return: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_COL && !cfg_r.addr_pipeline_sel) |=> mem_addr_o == $past(row_addr_i))
        else $error("row address not restored");

    a_addr_pipe: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_HOLD && cfg_r.addr_pipeline_sel && access_req_i) |=> $stable(mem_addr_o))
        else $error("column address dropped early");

    a_cfg_held: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r != ST_IDLE) |=> $stable(cfg_r))
        else $error("configuration changed mid cycle");

    c_access: cover property (@(posedge clk_i) state_r == ST_HOLD ##1 state_r == ST_IDLE);
    c_stagger: cover property (@(posedge clk_i) state_r == ST_REF && cfg_r.refresh_stagger_sel);
    c_pipe: cover property (@(posedge clk_i) state_r == ST_HOLD && cfg_r.addr_pipeline_sel);

endmodule : vram_bank_select_refresh_cfg

`default_nettype wire

// *** vram_array_model.sv ***
// Far-side model: the delay-line oscillator beside the VRAM array.
// Assumes the bench gates the oscillator so accesses see no refresh.
`default_nettype none

module vram_array_model (
    input wire logic clk_i,               // System clock
    input wire logic run_i,               // Oscillator enable
    output logic delay_line_clock_in_o    // Delay-line clock level
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] phase_r = 2'h0;

    // Quarter rate stays well under the clk/2 sampling limit
    always_ff @(posedge clk_i) begin
        if (run_i) begin
            phase_r <= phase_r + 2'h1;
        end
    end

    assign delay_line_clock_in_o = phase_r[1];
endmodule : vram_array_model

`default_nettype wire

// *** testbench.sv ***
// Bench for strobe decode, address mux, dividers and refresh sequencing.
// Assumes the package, the design modules and the array model compile first.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic req = 1'b0;
    logic bank_lo = 1'b0;
    logic bank_hi = 1'b0;
    logic [3:0] col_en = 4'hf;
    logic [10:0] row_a = 11'h2a5;
    logic [10:0] col_a = 11'h15a;
    logic run = 1'b0;
    logic delay_line_clock_in;
    logic [3:0] row_s;
    logic [3:0] col_s;
    logic [10:0] maddr;
    logic scrub;
    logic dtick;
    int n_fail = 0;
    int cmp_count = 0;

    always #50 clk_i = ~clk_i;

    vram_array_model far_end (.clk_i(clk_i), .run_i(run), .delay_line_clock_in_o(delay_line_clock_in));

    vram_bank_select_refresh_cfg uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .access_req_i(req),
        .bank_sel_lo_i(bank_lo), .bank_sel_hi_i(bank_hi), .byte_col_enable_i(col_en),
        .row_addr_i(row_a), .col_addr_i(col_a), .delay_line_clock_in_i(delay_line_clock_in), .row_strobe_o(row_s),
        .col_strobe_o(col_s), .mem_addr_o(maddr), .scrub_o(scrub), .delay_tick_o(dtick));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : cmp

    // Entered just after a rising edge; values seen at an edge are pre-update
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 20);
        if (t >= 20) n_fail++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic setcfg(input vram_cfg_pkg::cfg_t c);
        logic [31:0] q;
        logic [31:0] w;
        w = {22'h0, c[8:7], 1'b0, c[6:0]};
        wb(1'b1, vram_cfg_pkg::CFG_OFFSET, w, q);
        // A refresh in flight delays when the staged word takes effect
        repeat (8) @(posedge clk_i);
        wb(1'b0, vram_cfg_pkg::CFG_OFFSET, 32'h0, q);
        cmp(q, w);
        repeat (2) @(posedge clk_i);
    endtask : setcfg

    task automatic access(input logic [1:0] bk, input logic [3:0] en, input logic [3:0] er,
                          input logic [3:0] ec, input logic pipe);
        int t;
        t = 0;
        bank_hi <= bk[1];
        bank_lo <= bk[0];
        col_en <= en;
        req <= 1'b1;
        do begin
            @(posedge clk_i);
            t++;
        end while (row_s === 4'h0 && t < 20);
        cmp(32'(row_s), 32'(er));
        cmp(32'(maddr), 32'(row_a));
        @(posedge clk_i);
        cmp(32'(maddr), 32'(col_a));
        @(posedge clk_i);
        cmp(32'(col_s), 32'(ec));
        repeat (2) @(posedge clk_i);
        cmp(32'(maddr), 32'(pipe ? col_a : row_a));
        req <= 1'b0;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (row_s !== 4'h0 && t < 20);
        cmp(32'(col_s), 32'h0);
        @(posedge clk_i);
    endtask : access

    // Cycles between the second and third rise, past any reprogramming skew
    task automatic period(input logic refr, input int lim, output int n);
        logic p;
        logic h;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            h = 1'b1;
            do begin
                p = h;
                @(posedge clk_i);
                h = refr ? (row_s !== 4'h0) : (dtick === 1'b1);
                n++;
            end while (!(h && !p) && n < lim);
        end
    endtask : period

    initial begin
        vram_cfg_pkg::cfg_t c;
        logic [31:0] q;
        logic [3:0] er;
        int n;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, vram_cfg_pkg::CFG_OFFSET, 32'h0, q);
        cmp(q, {22'h0, vram_cfg_pkg::CFG_RESET});
        wb(1'b1, 4'h8, 32'h3ff, q);
        wb(1'b0, 4'h8, 32'h0, q);
        cmp(q, 32'h0);
        $display("register test done");
        for (int m = 4; m < 8; m++) begin
            c = '0;
            c.strobe_config_field = 3'(m);
            c.addr_pipeline_sel = m[0];
            setcfg(c);
            for (int b = 0; b < 4; b++) begin
                er = m[1] ? 4'h1 << b : (b[1] ? 4'hc : 4'h3);
                access(2'(b), ~(4'h1 << (3 - b)), er, (m[0] ? er : 4'hf) & ~(4'h1 << (3 - b)), m[0]);
            end
        end
        $display("strobe decode test done");
        run <= 1'b1;
        for (int d = 0; d < 8; d++) begin
            c = '0;
            c.clock_divisor_field = 3'(d);
            c.strobe_config_field = 3'h4;
            setcfg(c);
            period(1'b0, 100, n);
            cmp(32'(n), 32'((10 - d) * 4));
        end
        $display("divider test done");
        for (int r = 0; r < 4; r++) begin
            c = '0;
            c.clock_divisor_field = 3'h7;
            c.refresh_fine_divisor = r[0];
            c.refresh_stagger_sel = r[1];
            c.strobe_config_field = {1'b1, r[0], r[1]};
            setcfg(c);
            period(1'b1, 800, n);
            cmp(32'(n), 32'(12 * (r[0] ? 26 : 30)));
            cmp(32'(row_s), r[1] ? (r[0] ? 32'h1 : 32'h3) : 32'hf);
            cmp(32'(scrub), 32'h0);
            @(posedge clk_i);
            cmp(32'(row_s), r[1] ? (r[0] ? 32'h3 : 32'hf) : 32'hf);
            if (!r[1]) begin
                @(posedge clk_i);
                cmp(32'(row_s), 32'h0);
            end
        end
        $display("refresh test done");
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        end_of_test();
    end
endmodule : testbench

`default_nettype wire
